// ==== hw/urb_top.sv ====
// Receiver with four-word FIFO and break-character transmitter.
`timescale 1ns/100ps
module urb_top #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rxPin,
  input wire logic [DIV_W-1:0] baudDivisor,
  input wire urb_pkg::urb_cfg_t rxCfg,
  input wire logic statusAccess,
  input wire logic dataRead,
  input wire logic breakSendCtl,
  output logic txPin,
  output logic txIdleFlag,
  output logic rxIntReq,
  output urb_pkg::urb_stat_t rxStat
);
  import urb_pkg::*;

  typedef struct packed {
    logic [2:0] sync;
    logic line;
    logic lineHi;
    logic [DIV_W-1:0] divCnt;
    logic tick;
    urb_rxst_t rxSt;
    logic [3:0] ovs;
    logic [3:0] bitIdx;
    logic [2:0] smp;
    logic noisy;
    logic frameBad;
    logic [8:0] shift;
    logic [FIFO_DEPTH-1:0][8:0] mem;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W-1:0] wrPtr;
    logic armed;
    urb_stat_t stat;
    logic intReq;
    urb_txst_t txSt;
    logic [3:0] txOvs;
    logic [3:0] txBit;
    logic [DIV_W:0] holdCnt;
    logic brkArmed;
    logic txOut;
    logic txIdle;
  } urb_state_t;

  urb_state_t st_r;
  urb_state_t st_nxt;

  logic maj;
  logic [3:0] nData;
  logic [3:0] lastIdx;
  logic [8:0] word;
  logic parBad;
  logic pushReq;
  logic [DIV_W:0] holdLimit;

  always_comb begin
    st_nxt = st_r;
    maj = (st_r.smp[0] & st_r.smp[1]) | (st_r.smp[0] & st_r.smp[2]) |
          (st_r.smp[1] & st_r.smp[2]);
    nData = rxCfg.nineBitSel ? DATA9 : DATA8;
    lastIdx = nData + (rxCfg.rxStopCountSel ? 4'h2 : 4'h1);
    word = rxCfg.nineBitSel ? st_r.shift : {1'b0, st_r.shift[8:1]};
    parBad = 1'b0;
    pushReq = 1'b0;
    holdLimit = {1'b0, baudDivisor} + {{DIV_W{1'b0}}, 1'b1};

    // Three-stage pin synchroniser; the line only moves when stages two and three agree.
    st_nxt.sync = {st_r.sync[1:0], rxPin};
    if (st_r.sync[2] == st_r.sync[1]) begin
      st_nxt.line = st_r.sync[2];
    end
    if (st_r.line) begin
      st_nxt.lineHi = 1'b1;
    end

    // Oversampling enable at sixteen times the bit rate.
    st_nxt.tick = 1'b0;
    if (st_r.divCnt >= baudDivisor) begin
      st_nxt.divCnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.divCnt = st_r.divCnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end

    // Status access then data read: pop, then clear flags unless a set lands now.
    st_nxt.intReq = 1'b0;
    if (statusAccess) begin
      st_nxt.armed = 1'b1;
    end
    if (dataRead && st_r.armed) begin
      st_nxt.armed = 1'b0;
      st_nxt.stat.overrunFlag = 1'b0;
      st_nxt.stat.noiseFlag = 1'b0;
      if (st_r.stat.rxFillCount != '0) begin
        st_nxt.rdPtr = st_r.rdPtr + {{(PTR_W-1){1'b0}}, 1'b1};
        st_nxt.stat.rxFillCount = st_r.stat.rxFillCount - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (st_nxt.stat.rxFillCount == '0) begin
        st_nxt.stat.rxAvailFlag = 1'b0;
      end
    end

    if (!rxCfg.receiverOn) begin
      st_nxt.rxSt = RX_HUNT;
      st_nxt.stat.rxIdleFlag = 1'b1;
    end else if (st_r.tick) begin
      unique case (st_r.rxSt)
        RX_HUNT: begin
          // A low line only counts as a start once it has been seen high.
          if (!st_r.line && st_r.lineHi) begin
            st_nxt.rxSt = RX_BITS;
            st_nxt.ovs = '0;
            st_nxt.bitIdx = '0;
            st_nxt.noisy = 1'b0;
            st_nxt.frameBad = 1'b0;
            st_nxt.stat.rxIdleFlag = 1'b0;
          end
        end
        RX_BITS: begin
          st_nxt.ovs = st_r.ovs + 4'h1;
          if (st_r.ovs == SMP_A) begin
            st_nxt.smp[0] = st_r.line;
          end
          if (st_r.ovs == SMP_B) begin
            st_nxt.smp[1] = st_r.line;
          end
          if (st_r.ovs == SMP_C) begin
            st_nxt.smp[2] = st_r.line;
          end
          if (st_r.ovs == OVS_LAST) begin
            st_nxt.bitIdx = st_r.bitIdx + 4'h1;
            if (!(&st_r.smp) && (|st_r.smp)) begin
              st_nxt.noisy = 1'b1;
            end
            if (st_r.bitIdx == '0) begin
              // A start that votes high was a glitch; go back to hunting.
              if (maj) begin
                st_nxt.rxSt = RX_HUNT;
                st_nxt.stat.rxIdleFlag = 1'b1;
              end
            end else if (st_r.bitIdx <= nData) begin
              st_nxt.shift = {maj, st_r.shift[8:1]};
            end else begin
              if (!maj) begin
                st_nxt.frameBad = 1'b1;
              end
              if (st_r.bitIdx == lastIdx) begin
                st_nxt.rxSt = RX_HUNT;
                st_nxt.stat.rxIdleFlag = 1'b1;
                pushReq = 1'b1;
                if (!maj || st_r.frameBad) begin
                  st_nxt.lineHi = 1'b0;
                end
              end
            end
          end
        end
        default: begin
          st_nxt.rxSt = RX_HUNT;
        end
      endcase
    end

    unique case (rxCfg.parityTypeSel)
      PAR_EVEN: parBad = ^word;
      PAR_ODD: parBad = ~(^word);
      PAR_MARK: parBad = ~word[nData[3:0] == DATA9 ? 8 : 7];
      PAR_SPACE: parBad = word[nData[3:0] == DATA9 ? 8 : 7];
    endcase

    if (pushReq) begin
      if (st_nxt.stat.rxFillCount < CNT_W'(FIFO_DEPTH)) begin
        // A break votes all zeros, so the stored word is zero by itself.
        st_nxt.mem[st_r.wrPtr] = word;
        st_nxt.wrPtr = st_r.wrPtr + {{(PTR_W-1){1'b0}}, 1'b1};
        st_nxt.stat.rxFillCount = st_nxt.stat.rxFillCount + {{(CNT_W-1){1'b0}}, 1'b1};
        st_nxt.stat.rxAvailFlag = 1'b1;
        st_nxt.stat.frameErrFlag = st_r.frameBad | ~maj;
        st_nxt.stat.parityErrFlag = rxCfg.parityOn & parBad;
        if (st_r.noisy) begin
          st_nxt.stat.noiseFlag = 1'b1;
        end
        if (rxCfg.rxIntEn && st_nxt.stat.rxFillCount == rxCfg.rxTrigLevel) begin
          st_nxt.intReq = 1'b1;
        end
      end else begin
        // The word in the shifter is lost; stored words stay untouched.
        st_nxt.stat.overrunFlag = 1'b1;
        st_nxt.intReq = rxCfg.rxIntEn;
      end
    end

    st_nxt.stat.dataBufferReg = st_nxt.mem[st_nxt.rdPtr][7:0];
    st_nxt.stat.rxNinthBit = st_nxt.mem[st_nxt.rdPtr][8];

    // Break arming: the control must outlast divisor+1 clocks while idle.
    if (breakSendCtl && st_r.txIdle) begin
      if (st_r.holdCnt <= holdLimit) begin
        st_nxt.holdCnt = st_r.holdCnt + {{DIV_W{1'b0}}, 1'b1};
      end else begin
        st_nxt.brkArmed = 1'b1;
      end
    end else begin
      st_nxt.holdCnt = '0;
    end

    if (st_r.tick) begin
      unique case (st_r.txSt)
        TX_IDLE: begin
          if (st_r.brkArmed) begin
            st_nxt.txSt = TX_LOW;
            st_nxt.txOut = 1'b0;
            st_nxt.txIdle = 1'b0;
            st_nxt.txBit = '0;
            st_nxt.txOvs = '0;
            st_nxt.brkArmed = 1'b0;
          end
        end
        TX_LOW: begin
          st_nxt.txOvs = st_r.txOvs + 4'h1;
          if (st_r.txOvs == OVS_LAST) begin
            st_nxt.txBit = st_r.txBit + 4'h1;
            if (st_r.txBit == BRK_ZEROS) begin
              if (breakSendCtl) begin
                st_nxt.txBit = 4'h1;
              end else begin
                st_nxt.txSt = TX_STOP;
                st_nxt.txOut = 1'b1;
                st_nxt.txBit = '0;
              end
            end
          end
        end
        TX_STOP: begin
          st_nxt.txOvs = st_r.txOvs + 4'h1;
          if (st_r.txOvs == OVS_LAST) begin
            st_nxt.txBit = st_r.txBit + 4'h1;
            if (st_r.txBit == TX_RX_STOP_COUNT_SEL - 4'h1) begin
              // Only the idle flag rises here; no transmit interrupt exists for breaks.
              st_nxt.txSt = TX_IDLE;
              st_nxt.txIdle = 1'b1;
            end
          end
        end
        default: begin
          st_nxt.txSt = TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.sync <= SYNC_RESET;
      st_r.line <= 1'b1;
      st_r.stat.rxIdleFlag <= 1'b1;
      st_r.txOut <= 1'b1;
      st_r.txIdle <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txPin = st_r.txOut;
  assign txIdleFlag = st_r.txIdle;
  assign rxIntReq = st_r.intReq;
  assign rxStat = st_r.stat;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence sStopOut;
    st_r.txSt == TX_STOP ##1 st_r.txSt == TX_IDLE;
  endsequence

  sequence sSeqRead;
    st_r.armed && dataRead;
  endsequence

  AST_BRK_ARM: assert property ($rose(st_r.brkArmed) |-> $past(breakSendCtl, 2) && $past(st_r.holdCnt) > $past(holdLimit)) else $error("Break armed too early.");
  AST_BRK_LOW: assert property (st_r.txSt == TX_LOW |-> !txPin && !txIdleFlag) else $error("Break bit not low.");
  AST_STOP_OUT: assert property (sStopOut |-> txPin && txIdleFlag && $past(txPin)) else $error("Stop bits not high.");
  AST_FILL_AVAIL: assert property (rxStat.rxAvailFlag == (rxStat.rxFillCount != '0)) else $error("Available flag disagrees with fill count.");
  AST_OVR_KEEP: assert property ($rose(rxStat.overrunFlag) |-> rxStat.rxFillCount == CNT_W'(FIFO_DEPTH) && $stable(st_r.wrPtr)) else $error("Overrun altered FIFO.");
  AST_IDLE_LOW: assert property (st_r.rxSt == RX_BITS |-> !rxStat.rxIdleFlag) else $error("Idle high during frame.");
  AST_FE_WAIT: assert property (st_r.rxSt == RX_HUNT && !st_r.lineHi |=> st_r.rxSt == RX_HUNT) else $error("Start taken on low line.");
  // An overrun can repeat while its flag is still set, so a full FIFO with the flag up is allowed.
  AST_TRIG_INT: assert property (rxIntReq |-> rxStat.rxFillCount == rxCfg.rxTrigLevel || (rxStat.overrunFlag && rxStat.rxFillCount == CNT_W'(FIFO_DEPTH))) else $error("Interrupt off trigger level.");
  AST_AVAIL_CLR: assert property ($fell(rxStat.rxAvailFlag) |-> $past(st_r.armed && dataRead)) else $error("Available cleared without read sequence.");
  AST_OVR_CLR: assert property (sSeqRead ##1 !$past(pushReq) |-> !rxStat.overrunFlag) else $error("Overrun not cleared.");

endmodule

// ==== hw/urb_pkg.sv ====
// Constants and carrier types of the UART receiver with break transmit.
// Overview of operation
// - Break armed after control held over divisor+1 clocks.
// - Break is start plus thirteen-multiple zero bits.
// - Break sending raises no transmit interrupt.
// - After break control clears, send two rx_stop_count_sel.
// - Nine-bit mode puts MSB in ninth-bit field.
// - Oversample sixteen per bit, shift once per bit.
// - Each bit decided by three-sample majority vote.
// - After stop bit, word moves into buffer if room.
// - Serial data shifted in LSB first.
// - Four-word FIFO; fifth word dropped when full.
// - Overrun sets flag, keeps FIFO, requests interrupt.
// - Available flag while FIFO holds data; fill count.
// - Interrupt when FIFO reaches trigger level.
// - Available cleared only by status then data read.
// - Overrun cleared by status then data read.
// - Noise stores word, sets flag, no extra interrupt.
// - Break received as framing error, zero word stored.
// - After framing error wait for high line.
// - Idle flag low from start to stop bit.
// - Framing error when any stop bit samples low.
// - Parity error on mismatch of selected parity type.
// - Receiver enable starts start-bit search.
// - Receiver rx_stop_count_sel one or two; transmitter always two.
// - Two-bit parity type plus parity on bit.
package urb_pkg;

  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_B = 4'h8;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [3:0] DATA8 = 4'h8;
  localparam logic [3:0] DATA9 = 4'h9;
  localparam logic [3:0] BRK_ZEROS = 4'hD;
  localparam logic [3:0] TX_RX_STOP_COUNT_SEL = 4'h2;
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_MARK = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_BITS = 2'b01
  } urb_rxst_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOW = 2'b01,
    TX_STOP = 2'b10
  } urb_txst_t;

  typedef struct packed {
    logic receiverOn;
    logic nineBitSel;
    logic parityOn;
    logic [1:0] parityTypeSel;
    logic rxStopCountSel;
    logic rxIntEn;
    logic [CNT_W-1:0] rxTrigLevel;
  } urb_cfg_t;

  typedef struct packed {
    logic rxAvailFlag;
    logic overrunFlag;
    logic noiseFlag;
    logic frameErrFlag;
    logic parityErrFlag;
    logic rxIdleFlag;
    logic rxNinthBit;
    logic [CNT_W-1:0] rxFillCount;
    logic [7:0] dataBufferReg;
  } urb_stat_t;

endpackage

// ==== testbench/urb_line_partner.sv ====
// Remote serial transceiver model: drives the receive line, times breaks on the transmit line.
`timescale 1ns/100ps
module urb_line_partner #(
  parameter int BIT_CLKS = 32
) (
  clk,
  rxPin,
  txPin
);
  input wire logic clk;
  output logic rxPin;
  input wire logic txPin;

  initial rxPin = 1'b1;

  // Bits go out LSB first; the line returns high after the frame.
  // A two-clock glitch passes the synchroniser for two edges, and samples lie two clocks apart,
  // so it disturbs a single majority sample only, whatever the tick phase.
  task automatic send_bits(input logic [31:0] b, input int n, input int glitch);
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(negedge clk);
        rxPin = (i == glitch && c >= 18 && c < 20) ? ~b[i] : b[i];
      end
    end
    @(negedge clk);
    rxPin = 1'b1;
  endtask

  task automatic time_break(output int lowClks);
    lowClks = 0;
    while (txPin !== 1'b0) @(negedge clk);
    while (txPin === 1'b0) begin
      @(negedge clk);
      lowClks++;
    end
  endtask
endmodule

// ==== testbench/urb_top_tb.sv ====
// Self-checking bench for the receive FIFO, error flags and break transmit.
`timescale 1ns/100ps
module urb_top_tb;
  import urb_pkg::*;
  logic clk, resetn, rxPin, statusAccess, dataRead, breakSendCtl, txPin, txIdleFlag, rxIntReq;
  logic [15:0] baudDivisor;
  urb_cfg_t cfg;
  urb_stat_t st;
  int fail_count, comparisons, intSeen, intExp, lowClks, hiClks;
  int q[$];
  logic expOvr, expNoise, expFerr, expPerr;
  logic [31:0] seed;

  urb_top #(.DIV_W(16)) urb_top_i (.clk(clk), .resetn(resetn), .rxPin(rxPin),
    .baudDivisor(baudDivisor), .rxCfg(cfg), .statusAccess(statusAccess), .dataRead(dataRead),
    .breakSendCtl(breakSendCtl), .txPin(txPin), .txIdleFlag(txIdleFlag), .rxIntReq(rxIntReq),
    .rxStat(st));
  urb_line_partner urb_line_partner_i (.clk(clk), .rxPin(rxPin), .txPin(txPin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The request is a one-cycle register pulse, so it is counted mid-cycle where it has settled.
  always @(negedge clk) if (rxIntReq === 1'b1) intSeen++;

  function automatic logic [8:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[8:0];
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp_stat();
    check("fill", 32'(st.rxFillCount), 32'(q.size()));
    check("avail", 32'(st.rxAvailFlag), 32'(q.size() > 0));
    if (q.size() > 0) check("head", {st.rxNinthBit, st.dataBufferReg}, q[0]);
    check("ovr", 32'(st.overrunFlag), 32'(expOvr));
    check("noise", 32'(st.noiseFlag), 32'(expNoise));
    check("frame_err_flag", 32'(st.frameErrFlag), 32'(expFerr));
    check("parity_err_flag", 32'(st.parityErrFlag), 32'(expPerr));
    check("idle", 32'(st.rxIdleFlag), 32'h1);
    check("irq", intSeen, intExp);
  endtask

  // Software read: status access then data read; unarmed reads must change nothing.
  task automatic rd(input logic armed);
    @(negedge clk);
    statusAccess = armed;
    @(negedge clk);
    statusAccess = 1'b0;
    dataRead = 1'b1;
    @(negedge clk);
    dataRead = 1'b0;
    if (armed) begin
      if (q.size() > 0) void'(q.pop_front());
      expOvr = 1'b0;
      expNoise = 1'b0;
    end
    @(negedge clk);
    cmp_stat();
  endtask

  // Sends one frame; from bit lowAt on the line is held low, extra adds low or high bits.
  task automatic frame(input logic [8:0] w, input int rx_stop_count_sel, input int lowAt, input int extra,
                       input int glitch);
    logic [31:0] b;
    int nb;
    logic x;
    nb = cfg.nineBitSel ? 9 : 8;
    if (nb == 8) w[8] = 1'b0;
    b = '1;
    b[0] = 1'b0;
    for (int i = 0; i < nb; i++) b[i + 1] = w[i];
    for (int i = lowAt; lowAt > 0 && i < 32; i++) b[i] = 1'b0;
    urb_line_partner_i.send_bits(b, nb + 1 + rx_stop_count_sel + extra, glitch);
    repeat (8) @(negedge clk);
    x = cfg.parityTypeSel == PAR_MARK ? !w[nb-1] : cfg.parityTypeSel == PAR_SPACE ? w[nb-1] :
        (^w) ^ (cfg.parityTypeSel == PAR_ODD);
    if (cfg.receiverOn) begin
      if (q.size() == FIFO_DEPTH) begin
        expOvr = 1'b1;
        intExp += cfg.rxIntEn;
      end else begin
        q.push_back(w);
        expNoise |= (glitch >= 0);
        expFerr = (lowAt > 0);
        expPerr = cfg.parityOn & x;
        if (cfg.rxIntEn && q.size() == cfg.rxTrigLevel) intExp++;
      end
    end
    cmp_stat();
  endtask

  initial begin
    #1_000_000;
    fail_count++;
    end_of_test();
  end

  initial begin
    seed = 32'h0000000E;
    {resetn, statusAccess, dataRead, breakSendCtl} = 4'h0;
    baudDivisor = 16'h0001;
    cfg = '0;
    cfg.rxIntEn = 1'b1;
    cfg.rxTrigLevel = 3'h2;
    {expOvr, expNoise, expFerr, expPerr} = 4'h0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check("txrst", {txPin, txIdleFlag, rxIntReq}, 3'b110);
    cmp_stat();
    frame(rnd(), 1, -1, 0, -1);
    cfg.receiverOn = 1'b1;
    cfg.parityOn = 1'b1;
    for (int t = 0; t < 4; t++) begin
      cfg.parityTypeSel = t[1:0];
      frame(rnd(), 1, -1, 0, -1);
      frame(rnd(), 1, -1, 0, -1);
      rd(1'b1);
      rd(1'b1);
    end
    cfg.parityOn = 1'b0;
    frame(rnd(), 1, -1, 0, -1);
    rd(1'b0);
    rd(1'b1);
    repeat (5) frame(rnd(), 1, -1, 0, -1);
    repeat (5) rd(1'b1);
    cfg.nineBitSel = 1'b1;
    cfg.rxStopCountSel = 1'b1;
    frame(rnd(), 2, -1, 0, -1);
    frame(rnd(), 2, 11, 0, -1);
    repeat (2) rd(1'b1);
    cfg.nineBitSel = 1'b0;
    cfg.rxStopCountSel = 1'b0;
    frame(rnd(), 1, -1, 0, 3);
    rd(1'b1);
    frame(9'h000, 1, 9, 10, -1);
    frame(rnd(), 1, -1, 0, -1);
    repeat (2) rd(1'b1);
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      breakSendCtl = 1'b1;
      fork
        urb_line_partner_i.time_break(lowClks);
        begin
          repeat (k ? 600 : 200) @(negedge clk);
          breakSendCtl = 1'b0;
        end
      join
      hiClks = 0;
      while (txIdleFlag !== 1'b1) begin
        @(negedge clk);
        hiClks++;
      end
      check("brklow", lowClks, k ? 864 : 448);
      check("brkhi", 32'(hiClks >= 62 && hiClks <= 66), 32'h1);
      check("brkirq", intSeen, intExp);
    end
    end_of_test();
  end
endmodule
